/* File: sbx_pkg.sv */
package sbx_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int DATA_W = 8;
    localparam int PC_W = 8;
    localparam int PM_DEPTH = 256;
    localparam int DM_DEPTH = 256;
    localparam int STACK_DEPTH = 6;
    localparam int SP_W = 3;
    localparam int ADDR_W = 12;

    // ************************************************************
    // Instruction word
    // ************************************************************
    typedef enum logic [4:0] {
        OP_IDLE, OP_JUMP, OP_CALL, OP_COPY_M2W, OP_COPY_I2W, OP_COPY_W2M,
        OP_OR_M, OP_OR_I, OP_OR_TO_M, OP_SUB_EXIT, OP_SUB_EXIT_I,
        OP_IRQ_EXIT, OP_ROL, OP_ROL_W, OP_ROLC, OP_ROLC_W, OP_ROR, OP_ROR_W,
        OP_RORC, OP_RORC_W, OP_SUBB, OP_SUBB_TO_M, OP_DSZ, OP_DSZ_TO_W,
        OP_SET, OP_SET_BIT
    } sbx_op_t;

    typedef struct packed {
        sbx_op_t op;
        logic [2:0] bit_sel;
        logic [7:0] arg;
    } sbx_instr_t;

    typedef struct packed {
        logic signed_wrap;
        logic z;
        logic half_carry;
        logic c;
        logic signed_cmp;
        logic chained_nil;
    } sbx_flags_t;

    typedef enum logic {ST_RUN, ST_DUMMY} sbx_state_t;

    // ************************************************************
    // Constants
    // ************************************************************
    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [3:0] NIB_ZERO = 4'h0;
    localparam logic [PC_W-1:0] PC_ONE = 8'h01;
    localparam logic [PC_W-1:0] PC_TWO = 8'h02;
    localparam logic [PC_W-1:0] PC_RESET = 8'h00;
    localparam logic [PC_W-1:0] IRQ_VECTOR = 8'h04;
    localparam logic [SP_W-1:0] SP_ONE = 3'h1;
    localparam logic [SP_W-1:0] SP_TOP = 3'h6;
    localparam sbx_flags_t FLAGS_RESET = 6'h00;

    // ************************************************************
    // Register map (byte addresses) and fields
    // ************************************************************
    localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h004;
    localparam logic [ADDR_W-1:0] WORK_OFS = 12'h008;
    localparam logic [ADDR_W-1:0] FLAGS_OFS = 12'h00C;
    localparam logic [ADDR_W-1:0] PM_ADDR_OFS = 12'h010;
    localparam logic [ADDR_W-1:0] PM_DATA_OFS = 12'h014;
    localparam logic [ADDR_W-1:0] DM_ADDR_OFS = 12'h018;
    localparam logic [ADDR_W-1:0] DM_DATA_OFS = 12'h01C;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_IRQ_BIT = 1;
    localparam int STAT_GIE_BIT = 8;
    localparam int STAT_PEND_BIT = 9;
    localparam int STAT_SP_LSB = 12;

endpackage : sbx_pkg

/* File: sbx_alu.sv */
`timescale 1ns/10ps
module sbx_alu
    import sbx_pkg::*;
(
    input sbx_pkg::sbx_instr_t instr,
    input logic [7:0] work,
    input logic [7:0] mem,
    input sbx_pkg::sbx_flags_t flags,
    output logic [7:0] result,
    output sbx_pkg::sbx_flags_t next_flags,
    output logic wr_work,
    output logic wr_mem,
    output logic skip
);
    import sbx_pkg::*;

    logic [8:0] diff;
    logic [4:0] low_diff;

    // ************************************************************
    // Borrow chain for subtract-with-borrow
    // ************************************************************
    assign diff = {1'b0, work} - {1'b0, mem} - {8'h00, ~flags.c};
    assign low_diff = {1'b0, work[3:0]} - {1'b0, mem[3:0]}
        - {NIB_ZERO, ~flags.c};

    always_comb begin
        result = BYTE_ZERO;
        next_flags = flags;
        wr_work = 1'b0;
        wr_mem = 1'b0;
        skip = 1'b0;
        case (instr.op)
            OP_COPY_M2W: begin
                result = mem;
                wr_work = 1'b1;
            end
            OP_COPY_I2W: begin
                result = instr.arg;
                wr_work = 1'b1;
            end
            OP_COPY_W2M: begin
                result = work;
                wr_mem = 1'b1;
            end
            OP_OR_M, OP_OR_I, OP_OR_TO_M: begin
                result = work | ((instr.op == OP_OR_I) ? instr.arg : mem);
                next_flags.z = (result == BYTE_ZERO);
                wr_work = (instr.op != OP_OR_TO_M);
                wr_mem = (instr.op == OP_OR_TO_M);
            end
            OP_SUB_EXIT_I: begin
                result = instr.arg;
                wr_work = 1'b1;
            end
            OP_ROL, OP_ROL_W: begin
                result = {mem[6:0], mem[7]};
                wr_work = (instr.op == OP_ROL_W);
                wr_mem = (instr.op == OP_ROL);
            end
            OP_ROLC, OP_ROLC_W: begin
                result = {mem[6:0], flags.c};
                next_flags.c = mem[7];
                wr_work = (instr.op == OP_ROLC_W);
                wr_mem = (instr.op == OP_ROLC);
            end
            OP_ROR, OP_ROR_W: begin
                result = {mem[0], mem[7:1]};
                wr_work = (instr.op == OP_ROR_W);
                wr_mem = (instr.op == OP_ROR);
            end
            OP_RORC, OP_RORC_W: begin
                result = {flags.c, mem[7:1]};
                next_flags.c = mem[0];
                wr_work = (instr.op == OP_RORC_W);
                wr_mem = (instr.op == OP_RORC);
            end
            OP_SUBB, OP_SUBB_TO_M: begin
                result = diff[7:0];
                wr_work = (instr.op == OP_SUBB);
                wr_mem = (instr.op == OP_SUBB_TO_M);
                next_flags.c = ~diff[8];
                next_flags.half_carry = ~low_diff[4];
                next_flags.signed_wrap = (work[7] ^ mem[7])
                    & (work[7] ^ diff[7]);
                next_flags.z = (diff[7:0] == BYTE_ZERO);
                // Signed work >= operand when sign and overflow agree
                next_flags.signed_cmp = ~(diff[7] ^ next_flags.signed_wrap);
                // Chained zero keeps multi-byte compares honest
                next_flags.chained_nil = next_flags.z & flags.z;
            end
            OP_DSZ, OP_DSZ_TO_W: begin
                result = mem - BYTE_ONE;
                wr_work = (instr.op == OP_DSZ_TO_W);
                wr_mem = (instr.op == OP_DSZ);
                skip = (result == BYTE_ZERO);
            end
            OP_SET: begin
                result = ALL_ONES;
                wr_mem = 1'b1;
            end
            OP_SET_BIT: begin
                result = mem | (BYTE_ONE << instr.bit_sel);
                wr_mem = 1'b1;
            end
            default: begin
                result = BYTE_ZERO;
            end
        endcase
    end

endmodule : sbx_alu

/* File: sbx_core.sv */
`timescale 1ns/10ps
// How it works
// - Jump loads the target into the program counter and takes two cycles.
// - Copies move memory or immediate to work, or work to memory; no flags.
// - Idle changes nothing and just advances to the next instruction.
// - OR combines work with memory or immediate; only zero flag changes.
// - Return pops the counter; the immediate form also loads work.
// - Interrupt return pops the counter and sets the global enable.
// - A pending interrupt at interrupt return is serviced before resuming.
// - Rotate left moves bit 7 into bit 0; no flags.
// - To-work rotates write work, keep memory, same flags as memory form.
// - Rotate left through carry: bit 7 to carry, old carry to bit 0.
// - Rotate right moves bit 0 into bit 7; no flags.
// - Rotate right through carry: bit 0 to carry, old carry to bit 7.
// - Subtract-with-borrow: work minus memory minus inverted carry into work.
// - Memory form writes the same difference back to memory.
// - Carry clears on negative difference, sets on zero or positive.
// - Subtract updates wrap, zero, half carry, carry, signed and chain flags.
// - Decrement-skip writes memory minus one, skips on zero, no flags.
// - To-work decrement-skip writes work, keeps memory, skips on zero.
// - A skip instruction takes two cycles with a dummy cycle.
// - Set-byte writes all ones to memory; no flags.
// - Set-bit forces one selected bit to one; nothing else changes.
// - A call pushes the next address for later return.
module sbx_core
    import sbx_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sbx_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic ext_irq,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import sbx_pkg::*;

    logic [15:0] pmem [PM_DEPTH];
    logic [7:0] dmem [DM_DEPTH];
    logic [PC_W-1:0] stack [STACK_DEPTH];
    logic [PC_W-1:0] pc;
    logic [SP_W-1:0] sp;
    logic [7:0] work;
    logic [7:0] pm_addr;
    logic [7:0] dm_addr;
    sbx_flags_t flags;
    sbx_state_t state;
    logic run;
    logic gie;
    logic irq_pend;
    sbx_instr_t instr;
    logic [7:0] mem_val;
    logic [7:0] alu_res;
    sbx_flags_t alu_flags;
    logic alu_wr_work;
    logic alu_wr_mem;
    logic alu_skip;
    logic take_irq;
    logic exec;
    logic [PC_W-1:0] next_pc;
    sbx_state_t next_state;
    logic do_push;
    logic do_pop;
    logic [PC_W-1:0] push_val;
    logic [PC_W-1:0] top_val;
    logic gie_set;
    logic gie_clr;
    logic pend_clr;
    logic apb_wr;
    logic apb_err;
    logic [31:0] rd_val;

    // ************************************************************
    // Fetch and execute
    // ************************************************************
    assign instr = pmem[pc];
    assign mem_val = dmem[instr.arg];
    assign top_val = stack[sp - SP_ONE];
    assign take_irq = gie & irq_pend;
    assign exec = run & (state == ST_RUN) & ~take_irq;

    sbx_alu u_alu (
        .instr(instr),
        .work(work),
        .mem(mem_val),
        .flags(flags),
        .result(alu_res),
        .next_flags(alu_flags),
        .wr_work(alu_wr_work),
        .wr_mem(alu_wr_mem),
        .skip(alu_skip)
    );

    always_comb begin
        next_pc = pc;
        next_state = state;
        do_push = 1'b0;
        do_pop = 1'b0;
        push_val = pc;
        gie_set = 1'b0;
        gie_clr = 1'b0;
        pend_clr = 1'b0;
        if (run) begin
            if (state == ST_DUMMY) begin
                next_state = ST_RUN;
            end else if (take_irq) begin
                // Interrupt entry masks further requests until return
                do_push = 1'b1;
                gie_clr = 1'b1;
                pend_clr = 1'b1;
                next_pc = IRQ_VECTOR;
                next_state = ST_DUMMY;
            end else begin
                next_pc = pc + PC_ONE;
                case (instr.op)
                    OP_JUMP: begin
                        next_pc = instr.arg;
                        next_state = ST_DUMMY;
                    end
                    OP_CALL: begin
                        do_push = 1'b1;
                        push_val = pc + PC_ONE;
                        next_pc = instr.arg;
                        next_state = ST_DUMMY;
                    end
                    OP_SUB_EXIT, OP_SUB_EXIT_I: begin
                        do_pop = 1'b1;
                        next_pc = top_val;
                    end
                    OP_IRQ_EXIT: begin
                        do_pop = 1'b1;
                        next_pc = top_val;
                        if (irq_pend) begin
                            // Popped address goes straight back on the stack
                            do_push = 1'b1;
                            push_val = top_val;
                            pend_clr = 1'b1;
                            next_pc = IRQ_VECTOR;
                            next_state = ST_DUMMY;
                        end else begin
                            gie_set = 1'b1;
                        end
                    end
                    OP_DSZ, OP_DSZ_TO_W: begin
                        next_state = ST_DUMMY;
                        if (alu_skip) begin
                            next_pc = pc + PC_TWO;
                        end
                    end
                    default: begin
                        next_state = ST_RUN;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc <= PC_RESET;
            state <= ST_RUN;
        end else if (!run && apb_wr && paddr == CTRL_OFS) begin
            // Starting from halt always restarts at the reset address
            pc <= PC_RESET;
            state <= ST_RUN;
        end else begin
            pc <= next_pc;
            state <= next_state;
        end
    end

    // ************************************************************
    // Return-address stack
    // ************************************************************
    // Overflow past the top entry overwrites it, no trap is raised
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp <= '0;
        end else if (do_push && do_pop) begin
            stack[sp - SP_ONE] <= push_val;
        end else if (do_push) begin
            stack[(sp == SP_TOP) ? sp - SP_ONE : sp] <= push_val;
            sp <= (sp == SP_TOP) ? sp : sp + SP_ONE;
        end else if (do_pop && sp != '0) begin
            sp <= sp - SP_ONE;
        end
    end

    // ************************************************************
    // Work register, flags and interrupt state
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            work <= BYTE_ZERO;
        end else if (exec && alu_wr_work) begin
            work <= alu_res;
        end else if (!run && apb_wr && paddr == WORK_OFS) begin
            work <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= FLAGS_RESET;
        end else if (exec) begin
            flags <= alu_flags;
        end else if (!run && apb_wr && paddr == FLAGS_OFS) begin
            flags <= pwdata[5:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gie <= 1'b0;
        end else if (gie_set) begin
            gie <= 1'b1;
        end else if (gie_clr) begin
            gie <= 1'b0;
        end else if (apb_wr && paddr == STATUS_OFS) begin
            gie <= pwdata[STAT_GIE_BIT];
        end
    end

    // A new request wins over the clear of one being taken
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_pend <= 1'b0;
        end else if (ext_irq
            || (apb_wr && paddr == CTRL_OFS && pwdata[CTRL_IRQ_BIT])) begin
            irq_pend <= 1'b1;
        end else if (pend_clr) begin
            irq_pend <= 1'b0;
        end
    end

    // ************************************************************
    // Memories
    // ************************************************************
    always_ff @(posedge pclk) begin
        if (exec && alu_wr_mem) begin
            dmem[instr.arg] <= alu_res;
        end else if (!run && apb_wr && paddr == DM_DATA_OFS) begin
            dmem[dm_addr] <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk) begin
        if (!run && apb_wr && paddr == PM_DATA_OFS) begin
            pmem[pm_addr] <= pwdata[15:0];
        end
    end

    // ************************************************************
    // APB slave
    // ************************************************************
    function automatic logic reg_known(input logic [ADDR_W-1:0] a);
        reg_known = (a == CTRL_OFS) || (a == STATUS_OFS)
            || (a == WORK_OFS) || (a == FLAGS_OFS) || (a == PM_ADDR_OFS)
            || (a == PM_DATA_OFS) || (a == DM_ADDR_OFS)
            || (a == DM_DATA_OFS);
    endfunction : reg_known

    // Work, flags and memory data are only writable while halted to avoid torn updates
    function automatic logic reg_locked(input logic [ADDR_W-1:0] a);
        reg_locked = (a == WORK_OFS) || (a == FLAGS_OFS)
            || (a == PM_DATA_OFS) || (a == DM_DATA_OFS);
    endfunction : reg_locked

    assign apb_err = !reg_known(paddr) || (pwrite && run && reg_locked(paddr));
    assign apb_wr = psel & penable & pready & pwrite & ~pslverr;

    always_comb begin
        rd_val = 32'h0000_0000;
        if (paddr == CTRL_OFS) begin
            rd_val[CTRL_RUN_BIT] = run;
        end else if (paddr == STATUS_OFS) begin
            rd_val[PC_W-1:0] = pc;
            rd_val[STAT_GIE_BIT] = gie;
            rd_val[STAT_PEND_BIT] = irq_pend;
            rd_val[STAT_SP_LSB +: SP_W] = sp;
        end else if (paddr == WORK_OFS) begin
            rd_val[7:0] = work;
        end else if (paddr == FLAGS_OFS) begin
            rd_val[5:0] = flags;
        end else if (paddr == PM_ADDR_OFS) begin
            rd_val[7:0] = pm_addr;
        end else if (paddr == PM_DATA_OFS) begin
            rd_val[15:0] = pmem[pm_addr];
        end else if (paddr == DM_ADDR_OFS) begin
            rd_val[7:0] = dm_addr;
        end else if (paddr == DM_DATA_OFS) begin
            rd_val[7:0] = dmem[dm_addr];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= apb_err;
            prdata <= (pwrite || apb_err) ? 32'h0000_0000 : rd_val;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run <= 1'b0;
            pm_addr <= BYTE_ZERO;
            dm_addr <= BYTE_ZERO;
        end else if (apb_wr) begin
            if (paddr == CTRL_OFS) begin
                run <= pwdata[CTRL_RUN_BIT];
            end else if (paddr == PM_ADDR_OFS) begin
                pm_addr <= pwdata[7:0];
            end else if (paddr == DM_ADDR_OFS) begin
                dm_addr <= pwdata[7:0];
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    jump_target_a: assert property (
        exec && instr.op == OP_JUMP && !apb_wr
        |=> state == ST_DUMMY && pc == $past(instr.arg) ##1 state == ST_RUN)
        else $error("jump did not load target with one dummy cycle");

    copy_flags_a: assert property (
        exec && (instr.op == OP_COPY_M2W || instr.op == OP_COPY_I2W
        || instr.op == OP_COPY_W2M) |=> flags == $past(flags))
        else $error("copy changed flags");

    idle_step_a: assert property (
        exec && instr.op == OP_IDLE && !apb_wr
        |=> pc == $past(pc) + PC_ONE && work == $past(work)
        && flags == $past(flags))
        else $error("idle did more than advance");

    exit_enable_a: assert property (
        exec && instr.op == OP_IRQ_EXIT && !irq_pend && !ext_irq
        |=> gie && pc == $past(top_val))
        else $error("interrupt return did not enable and pop");

    exit_vector_a: assert property (
        exec && instr.op == OP_IRQ_EXIT && irq_pend && !apb_wr
        |=> pc == IRQ_VECTOR && !gie)
        else $error("pending interrupt not serviced on return");

    skip_cycles_a: assert property (
        exec && (instr.op == OP_DSZ || instr.op == OP_DSZ_TO_W) && !apb_wr
        |=> state == ST_DUMMY ##1 state == ST_RUN)
        else $error("skip did not take two cycles");

    call_push_a: assert property (
        exec && instr.op == OP_CALL && sp != SP_TOP
        |=> sp == $past(sp) + SP_ONE && top_val == $past(pc) + PC_ONE)
        else $error("call pushed wrong return address");

    single_cycle_a: assert property (
        exec && instr.op == OP_OR_I && !apb_wr
        |=> state == ST_RUN && pc == $past(pc) + PC_ONE)
        else $error("plain instruction not single cycle");

endmodule : sbx_core

/* File: tb_sbx_core.sv */
`timescale 1ns/10ps
module tb_sbx_core;
    import sbx_pkg::*;
    // ************************************************************
    // Signals
    // ************************************************************
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic ext_irq = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    int n_fail = 0;
    int check_count = 0;
    int seed = 32'h9B36D591;
    int k;
    logic [7:0] rnd;
    logic [15:0] pw [0:23] = '{default: 16'h0000};
    logic [7:0] dv [0:5];
    logic [45:0] note_q [$];

    always #2.5 pclk = ~pclk;

    sbx_core i_dut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .ext_irq(ext_irq),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr)
    );

    // ************************************************************
    // Checking
    // ************************************************************
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    // Sampled at the handshake edge, before the slave's own updates land
    always @(posedge pclk) begin : mon
        logic [45:0] n;
        if (psel && penable && pready === 1'b1) begin
            if (note_q.size() == 0) begin
                check("note queue", 32'h1, 32'h0);
            end else begin
                n = note_q.pop_front();
                check($sformatf("err %h", n[43:32]), {31'h0, pslverr},
                      {31'h0, n[44]});
                if (!n[45]) begin
                    check($sformatf("data %h", n[43:32]), prdata, n[31:0]);
                end
            end
        end
    end

    // ************************************************************
    // APB master
    // ************************************************************
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic e);
        int i;
        note_q.push_back({w, e, a, d});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= w ? d : 32'h0000_0000;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (i >= 20) begin
            n_fail++;
            $display("MISMATCH pready expected 1 seen timeout");
            complete_run();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic dm_read(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b1, DM_ADDR_OFS, {24'h0, a}, 1'b0);
        apb(1'b0, DM_DATA_OFS, {24'h0, exp}, 1'b0);
    endtask : dm_read

    // Loads the whole image and clears it for the next program
    task automatic load_pm;
        for (int j = 0; j < 24; j++) begin
            apb(1'b1, PM_ADDR_OFS, 32'(j), 1'b0);
            apb(1'b1, PM_DATA_OFS, {16'h0, pw[j]}, 1'b0);
            pw[j] = 16'h0000;
        end
    endtask : load_pm

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rnd = 8'($random(seed));
        apb(1'b0, WORK_OFS, 32'h0, 1'b0);
        apb(1'b0, FLAGS_OFS, 32'h0, 1'b0);
        apb(1'b0, 12'h020, 32'h0, 1'b1);
        dv = '{8'h81, 8'h01, 8'h05, rnd, 8'h00, 8'h00};
        for (k = 0; k < 6; k++) begin
            apb(1'b1, DM_ADDR_OFS, 32'(10 + k), 1'b0);
            apb(1'b1, DM_DATA_OFS, {24'h0, dv[k]}, 1'b0);
        end
        pw[0] = {OP_COPY_I2W, 3'h0, 8'h3C};
        pw[1] = {OP_OR_TO_M, 3'h0, 8'h0D};
        pw[2] = {OP_ROL, 3'h0, 8'h0A};
        pw[3] = {OP_ROR, 3'h0, 8'h0C};
        pw[4] = {OP_ROLC, 3'h0, 8'h0C};
        pw[5] = {OP_SUBB, 3'h0, 8'h0B};
        pw[6] = {OP_DSZ, 3'h0, 8'h0B};
        pw[7] = {OP_SET, 3'h0, 8'h0E};
        pw[8] = {OP_SET_BIT, 3'h3, 8'h0F};
        pw[9] = {OP_CALL, 3'h0, 8'h14};
        pw[10] = {OP_JUMP, 3'h0, 8'h0A};
        pw[20] = {OP_SUB_EXIT_I, 3'h0, 8'h77};
        load_pm();
        apb(1'b1, CTRL_OFS, 32'h1, 1'b0);
        apb(1'b1, WORK_OFS, 32'h55, 1'b1);
        repeat (40) @(posedge pclk);
        apb(1'b1, CTRL_OFS, 32'h0, 1'b0);
        // Loop parks on its own jump; stack empty after the return
        apb(1'b0, STATUS_OFS, 32'h0000_000A, 1'b0);
        apb(1'b0, WORK_OFS, 32'h77, 1'b0);
        // Borrow-free subtract: 3C - 01 - 0 gives ac, c, sc set
        apb(1'b0, FLAGS_OFS, 32'h0E, 1'b0);
        dm_read(8'h0A, 8'h03);
        dm_read(8'h0B, 8'h00);
        dm_read(8'h0C, 8'h04);
        dm_read(8'h0D, 8'h3C | rnd);
        dm_read(8'h0E, 8'h00);
        dm_read(8'h0F, 8'h08);
        // Second program: to-work forms, interrupt entry and return
        pw[1] = {OP_ROLC_W, 3'h0, 8'h0C};
        pw[2] = {OP_COPY_W2M, 3'h0, 8'h10};
        pw[3] = {OP_JUMP, 3'h0, 8'h08};
        pw[4] = {OP_IRQ_EXIT, 3'h0, 8'h00};
        pw[8] = {OP_RORC_W, 3'h0, 8'h0A};
        pw[9] = {OP_SUBB_TO_M, 3'h0, 8'h0C};
        pw[10] = {OP_RORC, 3'h0, 8'h0A};
        pw[11] = {OP_ROR_W, 3'h0, 8'h0F};
        pw[12] = {OP_COPY_W2M, 3'h0, 8'h11};
        pw[13] = {OP_ROL_W, 3'h0, 8'h0F};
        pw[14] = {OP_OR_M, 3'h0, 8'h10};
        pw[15] = {OP_COPY_W2M, 3'h0, 8'h12};
        pw[16] = {OP_COPY_M2W, 3'h0, 8'h11};
        pw[17] = {OP_OR_I, 3'h0, 8'h20};
        pw[18] = {OP_COPY_W2M, 3'h0, 8'h13};
        pw[19] = {OP_DSZ_TO_W, 3'h0, 8'h0B};
        pw[20] = {OP_CALL, 3'h0, 8'h17};
        pw[21] = {OP_JUMP, 3'h0, 8'h15};
        pw[23] = {OP_SUB_EXIT, 3'h0, 8'h00};
        load_pm();
        apb(1'b1, STATUS_OFS, 32'h0000_0100, 1'b0);
        // A request held high re-enters the vector from every return
        ext_irq <= 1'b1;
        apb(1'b1, CTRL_OFS, 32'h1, 1'b0);
        repeat (10) @(posedge pclk);
        ext_irq <= 1'b0;
        repeat (60) @(posedge pclk);
        apb(1'b1, CTRL_OFS, 32'h0, 1'b0);
        apb(1'b0, STATUS_OFS, 32'h0000_0115, 1'b0);
        apb(1'b0, WORK_OFS, 32'hFF, 1'b0);
        apb(1'b0, FLAGS_OFS, 32'h04, 1'b0);
        dm_read(8'h0A, 8'h01);
        dm_read(8'h0B, 8'h00);
        dm_read(8'h0C, 8'hFD);
        dm_read(8'h0F, 8'h08);
        dm_read(8'h10, 8'h09);
        dm_read(8'h11, 8'h04);
        dm_read(8'h12, 8'h19);
        dm_read(8'h13, 8'h24);
        complete_run();
    end

endmodule : tb_sbx_core
